// ---- core/ssup_core.v ----
// Per-second severity classification, defect-second and unavailable-second counting.
// Assumes error counts and defect levels come from framers on clock_in, and that
// sec_tick_in and interval_end_in are one-cycle pulses from system timing logic.
`include "ssup_defines.vh"
module ssup_core #(
  parameter EW = 4,   // Width of a per-cycle error count.
  parameter AW = 16,  // Width of a per-second error accumulator.
  parameter CW = 16   // Width of an interval counter.
) (
  input  wire          clock_in,
  input  wire          rstn_in,
  input  wire          sec_tick_in,
  input  wire          interval_end_in,
  input  wire [AW-1:0] section_k_in,
  input  wire [EW-1:0] pbit_err_in,
  input  wire [EW-1:0] cpbit_err_in,
  input  wire [EW-1:0] febe_bad_mframe_in,
  input  wire [EW-1:0] line_bpv_in,
  input  wire [EW-1:0] line_exz_in,
  input  wire [EW-1:0] sts_bip_in,
  input  wire [EW-1:0] far_sts_bip_in,
  input  wire [EW-1:0] vt_bip_in,
  input  wire [EW-1:0] section_bip_in,
  input  wire          ds3_sef_in,
  input  wire          ds3_ais_in,
  input  wire          far_ds3_defect_in,
  input  wire          section_sef_in,
  input  wire          section_los_in,
  input  wire          line_defect_in,
  input  wire          sts_ais_in,
  input  wire          sts_lop_in,
  input  wire          near_lower_defect_in,
  input  wire          far_lower_defect_in,
  input  wire          vt_ais_in,
  input  wire          vt_lop_in,
  input  wire          vt_lower_defect_in,
  input  wire          otn_section_severe_in,
  input  wire          otn_path_severe_in,
  output wire [CW-1:0] path_defect_seconds_out,
  output wire [CW-1:0] pbit_path_defect_seconds_out,
  output wire [CW-1:0] cpbit_path_defect_seconds_out,
  output wire [CW-1:0] section_framing_defect_seconds_out,
  output wire [CW-1:0] section_severe_seconds_out,
  output wire [CW-1:0] line_severe_seconds_out,
  output wire [CW-1:0] near_sts_path_severe_seconds_out,
  output wire [CW-1:0] far_sts_path_severe_seconds_out,
  output wire [CW-1:0] pbit_path_severe_seconds_out,
  output wire [CW-1:0] cpbit_path_severe_seconds_out,
  output wire [CW-1:0] far_cpbit_path_severe_seconds_out,
  output wire [CW-1:0] vt_path_severe_seconds_out,
  output wire [CW-1:0] otn_section_severe_seconds_out,
  output wire [CW-1:0] otn_path_severe_seconds_out,
  output wire [CW-1:0] line_unavailable_seconds_out,
  output wire [CW-1:0] near_sts_path_unavailable_seconds_out,
  output wire [CW-1:0] far_sts_path_unavailable_seconds_out,
  output wire [CW-1:0] cpbit_path_unavailable_seconds_out,
  output wire [CW-1:0] far_cpbit_path_unavailable_seconds_out,
  output wire [CW-1:0] otn_path_unavailable_seconds_out,
  output wire [15:0]   otn_section_severe_ratio_out,
  output wire [15:0]   otn_path_severe_ratio_out,
  output wire          report_valid_out
);

  localparam NE = 9;   // Number of error accumulators.
  localparam ND = 15;  // Number of defect latches.
  localparam NS = 14;  // Number of per-second classification counters.
  localparam NU = 6;   // Number of unavailable-time trackers.

  // Per-cycle error counts packed in accumulator order.
  wire [NE*EW-1:0] err_w = {section_bip_in, vt_bip_in, far_sts_bip_in, sts_bip_in, line_exz_in,
                            line_bpv_in, febe_bad_mframe_in, cpbit_err_in, pbit_err_in};
  // Defect levels packed in latch order.
  wire [ND-1:0] def_w = {otn_path_severe_in, otn_section_severe_in, vt_lower_defect_in, vt_lop_in,
                         vt_ais_in, far_lower_defect_in, near_lower_defect_in, sts_lop_in, sts_ais_in,
                         line_defect_in, section_los_in, section_sef_in, far_ds3_defect_in,
                         ds3_ais_in, ds3_sef_in};
  wire [NE*AW-1:0] sum_w;         // Error totals of the running second, this cycle included.
  reg  [ND-1:0]    seen_q;        // Defects seen so far in the running second.
  wire [ND-1:0]    seen_w = seen_q | def_w; // Defects of the second, this cycle included.
  wire [NS-1:0]    sev_w;         // Classification of the second that ends at the tick.
  wire [NS*CW-1:0] rpt_w;         // Frozen classification counts.
  wire [NU*CW-1:0] urpt_w;        // Frozen unavailable-second counts.
  wire [NS*CW-1:0] cnt_w;         // Running classification counts with this cycle's step.
  reg              rvalid_q;      // Pulses for one cycle after a report is frozen.
  reg  [CW-1:0]    secs_q;        // Seconds elapsed in the running interval.
  reg  [15:0]      osm_ratio_q;   // Frozen OTN section severe ratio.
  reg  [15:0]      opm_ratio_q;   // Frozen OTN path severe ratio.

  // One saturating accumulator per error source, cleared on each tick.
  genvar gi;
  generate
    for (gi = 0; gi < NE; gi = gi + 1) begin : g_acc
      reg  [AW-1:0] acc_q;  // Errors counted so far in the running second.
      wire [AW:0]   raw_w = {1'b0, acc_q} + {{(AW+1-EW){1'b0}}, err_w[gi*EW +: EW]};
      // Saturate so a burst cannot wrap below a threshold.
      assign sum_w[gi*AW +: AW] = raw_w[AW] ? {AW{1'b1}} : raw_w[AW-1:0];
      // Clear on the tick so the next second starts empty.
      always @(posedge clock_in) begin
        if (!rstn_in) begin
          acc_q <= {AW{1'b0}};
        end else if (sec_tick_in) begin
          acc_q <= {AW{1'b0}};
        end else begin
          acc_q <= sum_w[gi*AW +: AW];
        end
      end
    end
  endgenerate

  // Defect latches hold any defect level seen during the second.
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      seen_q <= {ND{1'b0}};
    end else if (sec_tick_in) begin
      seen_q <= {ND{1'b0}};
    end else begin
      seen_q <= seen_w;
    end
  end

  // Named totals for the second that closes at this tick.
  wire [AW-1:0] pbit_w  = sum_w[0*AW +: AW];
  wire [AW-1:0] cpbit_w = sum_w[1*AW +: AW];
  wire [AW-1:0] febe_w  = sum_w[2*AW +: AW];
  wire [AW:0]   line_w  = {1'b0, sum_w[3*AW +: AW]} + {1'b0, sum_w[4*AW +: AW]};
  wire [AW-1:0] nsts_w  = sum_w[5*AW +: AW];
  wire [AW-1:0] fsts_w  = sum_w[6*AW +: AW];
  wire [AW-1:0] vt_w    = sum_w[7*AW +: AW];
  wire [AW-1:0] sbip_w  = sum_w[8*AW +: AW];
  wire          ds3d_w  = seen_w[0] | seen_w[1]; // Framing or AIS on the DS-3 path.

  // Per-second classifications, consumed only on the tick.
  assign sev_w[`SSUP_S_PATH_DEF]   = ds3d_w;
  assign sev_w[`SSUP_S_PBIT_DEF]   = ds3d_w;
  assign sev_w[`SSUP_S_CPBIT_DEF]  = ds3d_w;
  assign sev_w[`SSUP_S_SEC_FRAME]  = seen_w[3];
  assign sev_w[`SSUP_S_SEC_SEV]    = (sbip_w >= section_k_in) | seen_w[3] | seen_w[4];
  assign sev_w[`SSUP_S_LINE_SEV]   = (line_w >= `SSUP_LINE_LIMIT) | seen_w[5];
  assign sev_w[`SSUP_S_NSTS_SEV]   = (nsts_w >= `SSUP_STS_LIMIT) | seen_w[6] | seen_w[7] | seen_w[8];
  assign sev_w[`SSUP_S_FSTS_SEV]   = (fsts_w >= `SSUP_STS_LIMIT) | seen_w[6] | seen_w[7] | seen_w[9];
  assign sev_w[`SSUP_S_PBIT_SEV]   = (pbit_w > `SSUP_DS3_PAR_LIMIT) | ds3d_w;
  assign sev_w[`SSUP_S_CPBIT_SEV]  = (cpbit_w > `SSUP_DS3_PAR_LIMIT) | ds3d_w;
  assign sev_w[`SSUP_S_FCPBIT_SEV] = (febe_w >= `SSUP_FEBE_LIMIT) | seen_w[2];
  assign sev_w[`SSUP_S_VT_SEV]     = (vt_w >= `SSUP_VT_LIMIT) | seen_w[10] | seen_w[11] | seen_w[12];
  assign sev_w[`SSUP_S_OSM_SEV]    = seen_w[13];
  assign sev_w[`SSUP_S_OPM_SEV]    = seen_w[14];

  // One interval counter per classification, frozen and restarted at interval end.
  generate
    for (gi = 0; gi < NS; gi = gi + 1) begin : g_cnt
      reg [CW-1:0] c_q;  // Running count.
      reg [CW-1:0] r_q;  // Frozen count of the last interval.
      wire         step_w = sec_tick_in & sev_w[gi] & ~(&c_q);
      assign cnt_w[gi*CW +: CW] = c_q + {{(CW-1){1'b0}}, step_w};
      assign rpt_w[gi*CW +: CW] = r_q;
      // A tick in the closing cycle still lands in the closing interval.
      always @(posedge clock_in) begin
        if (!rstn_in) begin
          c_q <= {CW{1'b0}};
          r_q <= {CW{1'b0}};
        end else if (interval_end_in) begin
          r_q <= cnt_w[gi*CW +: CW];
          c_q <= {CW{1'b0}};
        end else begin
          c_q <= cnt_w[gi*CW +: CW];
        end
      end
    end
  endgenerate

  // Severity sources of the unavailable-time trackers.
  wire [NU-1:0] usev_w = {sev_w[`SSUP_S_OPM_SEV], sev_w[`SSUP_S_FCPBIT_SEV], sev_w[`SSUP_S_CPBIT_SEV],
                          sev_w[`SSUP_S_FSTS_SEV], sev_w[`SSUP_S_NSTS_SEV], sev_w[`SSUP_S_LINE_SEV]};

  // Ten-second entry and exit trackers; entry seconds counted, exit seconds removed.
  generate
    for (gi = 0; gi < NU; gi = gi + 1) begin : g_uas
      reg          un_q;   // Path is unavailable.
      reg  [3:0]   run_q;  // Length of the current run of qualifying seconds.
      reg  [CW-1:0] u_q;   // Running unavailable seconds of the interval.
      reg  [CW-1:0] ur_q;  // Frozen unavailable seconds of the last interval.
      reg          un_d;
      reg  [3:0]   run_d;
      reg  [CW:0]  u_d;    // One spare bit to catch saturation and underflow.
      wire         last_w = (run_q == `SSUP_UAS_RUN - 4'h1); // This second completes a run of ten.
      wire [CW-1:0] uc_w = u_d[CW] ? (un_q & ~un_d ? {CW{1'b0}} : {CW{1'b1}}) : u_d[CW-1:0];
      assign urpt_w[gi*CW +: CW] = ur_q;
      // Next state of the tracker on a tick.
      always @* begin
        un_d  = un_q;
        run_d = run_q;
        u_d   = {1'b0, u_q};
        if (sec_tick_in) begin
          if (!un_q) begin
            if (!usev_w[gi]) begin
              run_d = 4'h0;
            end else if (last_w) begin
              un_d  = 1'b1;
              run_d = 4'h0;
              u_d   = {1'b0, u_q} + {{(CW-3){1'b0}}, `SSUP_UAS_RUN};
            end else begin
              run_d = run_q + 4'h1;
            end
          end else begin
            u_d = {1'b0, u_q} + {{CW{1'b0}}, 1'b1};
            if (usev_w[gi]) begin
              run_d = 4'h0;
            end else if (last_w) begin
              un_d  = 1'b0;
              run_d = 4'h0;
              u_d   = {1'b0, u_q} - {{(CW-3){1'b0}}, `SSUP_UAS_RUN - 4'h1};
            end else begin
              run_d = run_q + 4'h1;
            end
          end
        end
      end
      // State update; the count is frozen and restarted at interval end.
      always @(posedge clock_in) begin
        if (!rstn_in) begin
          un_q  <= 1'b0;
          run_q <= 4'h0;
          u_q   <= {CW{1'b0}};
          ur_q  <= {CW{1'b0}};
        end else begin
          un_q  <= un_d;
          run_q <= run_d;
          if (interval_end_in) begin
            ur_q <= uc_w;
            u_q  <= {CW{1'b0}};
          end else begin
            u_q  <= uc_w;
          end
        end
      end
    end
  endgenerate

  // Interval length in seconds, the divisor of the severe ratios.
  wire [CW-1:0]    secs_w  = secs_q + {{(CW-1){1'b0}}, sec_tick_in & ~(&secs_q)};
  wire [CW+15:0]   osm_n_w = {cnt_w[`SSUP_S_OSM_SEV*CW +: CW], 16'h0000};
  wire [CW+15:0]   opm_n_w = {cnt_w[`SSUP_S_OPM_SEV*CW +: CW], 16'h0000};
  wire [CW+15:0]   osm_q_w = osm_n_w / {16'h0000, secs_w};
  wire [CW+15:0]   opm_q_w = opm_n_w / {16'h0000, secs_w};

  // Ratios are severe seconds over elapsed seconds in 0.16 fixed point, saturated at all ones.
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      secs_q      <= {CW{1'b0}};
      osm_ratio_q <= 16'h0000;
      opm_ratio_q <= 16'h0000;
      rvalid_q    <= 1'b0;
    end else begin
      rvalid_q <= interval_end_in;
      if (interval_end_in) begin
        secs_q <= {CW{1'b0}};
        if (secs_w == {CW{1'b0}}) begin
          osm_ratio_q <= 16'h0000;
          opm_ratio_q <= 16'h0000;
        end else begin
          osm_ratio_q <= (|osm_q_w[CW+15:16]) ? 16'hFFFF : osm_q_w[15:0];
          opm_ratio_q <= (|opm_q_w[CW+15:16]) ? 16'hFFFF : opm_q_w[15:0];
        end
      end else begin
        secs_q <= secs_w;
      end
    end
  end

  // Report ports straight from the frozen registers.
  assign path_defect_seconds_out               = rpt_w[`SSUP_S_PATH_DEF*CW +: CW];
  assign pbit_path_defect_seconds_out          = rpt_w[`SSUP_S_PBIT_DEF*CW +: CW];
  assign cpbit_path_defect_seconds_out         = rpt_w[`SSUP_S_CPBIT_DEF*CW +: CW];
  assign section_framing_defect_seconds_out    = rpt_w[`SSUP_S_SEC_FRAME*CW +: CW];
  assign section_severe_seconds_out            = rpt_w[`SSUP_S_SEC_SEV*CW +: CW];
  assign line_severe_seconds_out               = rpt_w[`SSUP_S_LINE_SEV*CW +: CW];
  assign near_sts_path_severe_seconds_out      = rpt_w[`SSUP_S_NSTS_SEV*CW +: CW];
  assign far_sts_path_severe_seconds_out       = rpt_w[`SSUP_S_FSTS_SEV*CW +: CW];
  assign pbit_path_severe_seconds_out          = rpt_w[`SSUP_S_PBIT_SEV*CW +: CW];
  assign cpbit_path_severe_seconds_out         = rpt_w[`SSUP_S_CPBIT_SEV*CW +: CW];
  assign far_cpbit_path_severe_seconds_out     = rpt_w[`SSUP_S_FCPBIT_SEV*CW +: CW];
  assign vt_path_severe_seconds_out            = rpt_w[`SSUP_S_VT_SEV*CW +: CW];
  assign otn_section_severe_seconds_out        = rpt_w[`SSUP_S_OSM_SEV*CW +: CW];
  assign otn_path_severe_seconds_out           = rpt_w[`SSUP_S_OPM_SEV*CW +: CW];
  assign line_unavailable_seconds_out          = urpt_w[0*CW +: CW];
  assign near_sts_path_unavailable_seconds_out = urpt_w[1*CW +: CW];
  assign far_sts_path_unavailable_seconds_out  = urpt_w[2*CW +: CW];
  assign cpbit_path_unavailable_seconds_out    = urpt_w[3*CW +: CW];
  assign far_cpbit_path_unavailable_seconds_out = urpt_w[4*CW +: CW];
  assign otn_path_unavailable_seconds_out      = urpt_w[5*CW +: CW];
  assign otn_section_severe_ratio_out          = osm_ratio_q;
  assign otn_path_severe_ratio_out             = opm_ratio_q;
  assign report_valid_out                      = rvalid_q;

endmodule // ssup_core

// ---- core/ssup_defines.vh ----
// Constants for the per-second severity and unavailability monitor.
// Assumes it is included once by core/ssup_core.v; it holds definitions only.
`ifndef SSUP_DEFINES_VH
`define SSUP_DEFINES_VH
// DS-3 parity and far-end block error thresholds per second.
`define SSUP_DS3_PAR_LIMIT   16'h002C
`define SSUP_FEBE_LIMIT      16'h002C
// Line bipolar-violation plus excess-zero threshold per second.
`define SSUP_LINE_LIMIT      17'h0002C
// STS path BIP threshold per second (2400).
`define SSUP_STS_LIMIT       16'h0960
// VT path BIP threshold per second (600).
`define SSUP_VT_LIMIT        16'h0258
// Consecutive seconds that enter or leave unavailable time.
`define SSUP_UAS_RUN         4'hA
// Severity flag positions.
`define SSUP_S_PATH_DEF      0
`define SSUP_S_PBIT_DEF      1
`define SSUP_S_CPBIT_DEF     2
`define SSUP_S_SEC_FRAME     3
`define SSUP_S_SEC_SEV       4
`define SSUP_S_LINE_SEV      5
`define SSUP_S_NSTS_SEV      6
`define SSUP_S_FSTS_SEV      7
`define SSUP_S_PBIT_SEV      8
`define SSUP_S_CPBIT_SEV     9
`define SSUP_S_FCPBIT_SEV    10
`define SSUP_S_VT_SEV        11
`define SSUP_S_OSM_SEV       12
`define SSUP_S_OPM_SEV       13
`endif

// ---- verif/ssup_core_bench.sv ----
// Self-checking bench for the severity and unavailability monitor.
// Assumes inputs change on the falling edge and the design samples on the rising edge.
module ssup_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clock_in = 1'b0;
  logic             rstn_in = 1'b0;
  logic             sec_tick_in = 1'b0;
  logic             interval_end_in = 1'b0;
  logic             go = 1'b0;          // Framer model emits errors while high.
  logic [15:0]      section_k_in = 16'h001E;
  logic [8:0][15:0] tot = '0;           // Error totals per channel for a second.
  logic [14:0]      dfx = '0;           // Defect levels, one bit per defect input.
  logic [15:0]      exp_v [0:21];       // Expected report values.
  wire  [8:0][3:0]  err;
  wire  [15:0]      o [0:21];
  wire              valid;
  int               n_mismatch = 0;
  int               total_checks = 0;
  always #5 clock_in = ~clock_in;
  ssup_framer_model ssup_framer_model_i (.clock_in(clock_in), .rstn_in(rstn_in), .tick_in(sec_tick_in),
    .go_in(go), .total_in(tot), .err_out(err));
  ssup_core #(.EW(4), .AW(16), .CW(16)) ssup_core_i (.clock_in(clock_in), .rstn_in(rstn_in),
    .sec_tick_in(sec_tick_in), .interval_end_in(interval_end_in), .section_k_in(section_k_in),
    .pbit_err_in(err[0]), .cpbit_err_in(err[1]), .febe_bad_mframe_in(err[2]), .line_bpv_in(err[3]),
    .line_exz_in(err[4]), .sts_bip_in(err[5]), .far_sts_bip_in(err[6]), .vt_bip_in(err[7]),
    .section_bip_in(err[8]), .ds3_sef_in(dfx[0]), .ds3_ais_in(dfx[1]), .far_ds3_defect_in(dfx[2]),
    .section_sef_in(dfx[3]), .section_los_in(dfx[4]), .line_defect_in(dfx[5]), .sts_ais_in(dfx[6]),
    .sts_lop_in(dfx[7]), .near_lower_defect_in(dfx[8]), .far_lower_defect_in(dfx[9]), .vt_ais_in(dfx[10]),
    .vt_lop_in(dfx[11]), .vt_lower_defect_in(dfx[12]), .otn_section_severe_in(dfx[13]),
    .otn_path_severe_in(dfx[14]), .path_defect_seconds_out(o[0]), .pbit_path_defect_seconds_out(o[1]),
    .cpbit_path_defect_seconds_out(o[2]), .section_framing_defect_seconds_out(o[3]),
    .section_severe_seconds_out(o[4]), .line_severe_seconds_out(o[5]), .near_sts_path_severe_seconds_out(o[6]),
    .far_sts_path_severe_seconds_out(o[7]), .pbit_path_severe_seconds_out(o[8]),
    .cpbit_path_severe_seconds_out(o[9]), .far_cpbit_path_severe_seconds_out(o[10]),
    .vt_path_severe_seconds_out(o[11]), .otn_section_severe_seconds_out(o[12]),
    .otn_path_severe_seconds_out(o[13]), .line_unavailable_seconds_out(o[14]),
    .near_sts_path_unavailable_seconds_out(o[15]), .far_sts_path_unavailable_seconds_out(o[16]),
    .cpbit_path_unavailable_seconds_out(o[17]), .far_cpbit_path_unavailable_seconds_out(o[18]),
    .otn_path_unavailable_seconds_out(o[19]), .otn_section_severe_ratio_out(o[20]),
    .otn_path_severe_ratio_out(o[21]), .report_valid_out(valid));
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Compares one value and reports a difference at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, want);
    end
  endtask
  // Runs one second of cyc cycles with defects d held, then a tick.
  task automatic one_sec(input logic [14:0] d, input int cyc);
    @(negedge clock_in);
    dfx = d;
    go = 1'b1;
    repeat (cyc) @(negedge clock_in);
    go = 1'b0;
    sec_tick_in = 1'b1;
    @(negedge clock_in);
    sec_tick_in = 1'b0;
    dfx = '0;
  endtask
  // Closes the interval and compares report outputs lo to hi.
  task automatic close_iv(input int lo, input int hi);
    interval_end_in = 1'b1;
    @(negedge clock_in);
    interval_end_in = 1'b0;
    check({15'h0000, valid}, 16'h0001);
    for (int i = lo; i <= hi; i++) check(o[i], exp_v[i]);
  endtask
  // Each error threshold exactly at and just beside its boundary.
  task automatic t_thresh();
    tot = {16'h001E, 16'h0258, 16'h0960, 16'h0960, 16'h0016, 16'h0016, 16'h002C, 16'h002C, 16'h002C};
    one_sec(15'h0000, 170);
    tot = {16'h001D, 16'h0257, 16'h095F, 16'h095F, 16'h0015, 16'h0016, 16'h002B, 16'h002D, 16'h002D};
    one_sec(15'h0000, 170);
    exp_v = '{default: 16'h0000};
    for (int i = 4; i < 12; i++) exp_v[i] = 16'h0001;
    close_iv(0, 21);
    $display("threshold test done");
  endtask
  // One second per defect input, each alone.
  task automatic t_defects();
    tot = '0;
    for (int i = 0; i < 15; i++) one_sec(15'h0001 << i, 2);
    // One OTN severe second in fifteen gives 65536/15, truncated, in 0.16 fixed point.
    exp_v = '{16'h0002, 16'h0002, 16'h0002, 16'h0001, 16'h0002, 16'h0001, 16'h0003, 16'h0003, 16'h0002,
      16'h0002, 16'h0001, 16'h0003, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h1111, 16'h1111};
    close_iv(0, 21);
    $display("defect test done");
  endtask
  // Nine severe seconds do not enter; twelve do, then ten clear seconds leave.
  task automatic t_unavail();
    one_sec(15'h0000, 2);
    repeat (9) one_sec(15'h4065, 2);
    one_sec(15'h0000, 2);
    repeat (12) one_sec(15'h4065, 2);
    repeat (10) one_sec(15'h0000, 2);
    exp_v = '{default: 16'h000C};
    exp_v[5] = 16'h0015;
    close_iv(14, 19);
    check(o[5], exp_v[5]);
    $display("unavailable test done");
  endtask
  // A tick in the same cycle as the interval end still lands in the closing interval.
  task automatic t_overlap();
    @(negedge clock_in);
    dfx = 15'h2000;
    sec_tick_in = 1'b1;
    interval_end_in = 1'b1;
    @(negedge clock_in);
    dfx = '0;
    sec_tick_in = 1'b0;
    interval_end_in = 1'b0;
    check({15'h0000, valid}, 16'h0001);
    check(o[12], 16'h0001);
    check(o[5], 16'h0000);
    check(o[20], 16'hFFFF);
    check(o[21], 16'h0000);
    check(o[19], 16'h0000);
    $display("overlap test done");
  endtask
  // Main sequence after a six-cycle reset.
  initial begin
    repeat (6) @(negedge clock_in);
    rstn_in = 1'b1;
    t_thresh();
    t_defects();
    t_unavail();
    t_overlap();
    test_done();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule // ssup_core_bench

// ---- verif/ssup_core_properties.sv ----
// Checker for the reporting side of the severity monitor.
// Assumes it is bound to ssup_core and sees only that module's ports.
module ssup_core_properties #(
  parameter CW = 16  // Width of an interval counter.
) (
  input wire logic          clock_in,
  input wire logic          rstn_in,
  input wire logic          interval_end_in,
  input wire logic [CW-1:0] path_defect_seconds_out,
  input wire logic [CW-1:0] line_severe_seconds_out,
  input wire logic [CW-1:0] line_unavailable_seconds_out,
  input wire logic [CW-1:0] otn_section_severe_seconds_out,
  input wire logic [CW-1:0] otn_path_severe_seconds_out,
  input wire logic [15:0]   otn_section_severe_ratio_out,
  input wire logic [15:0]   otn_path_severe_ratio_out,
  input wire logic          report_valid_out
);
  // All checks run on the one system clock; all but a_reset_clears pause while reset is low.
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);
  a_valid_follows_end: assert property (interval_end_in |=> report_valid_out)
    else $error("report valid missing after interval end");
  a_valid_needs_end: assert property (report_valid_out |-> $past(interval_end_in))
    else $error("report valid without interval end");
  a_reset_clears: assert property (@(posedge clock_in) disable iff (1'b0)
    !rstn_in |=> line_severe_seconds_out == 16'h0000 && !report_valid_out)
    else $error("outputs not cleared by reset");
  a_defect_holds: assert property (!interval_end_in |=> $stable(path_defect_seconds_out))
    else $error("defect count moved inside an interval");
  a_line_holds: assert property (!$past(interval_end_in) |-> $stable(line_severe_seconds_out))
    else $error("line count moved inside an interval");
  a_unavail_holds: assert property (!interval_end_in ##1 !interval_end_in |=>
    $stable(line_unavailable_seconds_out)) else $error("unavailable count moved inside an interval");
  a_ratio_holds: assert property (!interval_end_in |=> $stable(otn_path_severe_ratio_out))
    else $error("ratio moved inside an interval");
  a_ratio_zero: assert property ($rose(report_valid_out) && otn_path_severe_seconds_out == 16'h0000
    |-> otn_path_severe_ratio_out == 16'h0000) else $error("ratio nonzero with no severe second");
  a_ratio_nonzero: assert property ($rose(report_valid_out) && otn_section_severe_seconds_out != 16'h0000
    |-> otn_section_severe_ratio_out != 16'h0000) else $error("ratio zero with severe seconds");
endmodule // ssup_core_properties
bind ssup_core ssup_core_properties #(.CW(CW)) ssup_core_properties_i (.clock_in(clock_in), .rstn_in(rstn_in),
  .interval_end_in(interval_end_in), .path_defect_seconds_out(path_defect_seconds_out),
  .line_severe_seconds_out(line_severe_seconds_out), .line_unavailable_seconds_out(line_unavailable_seconds_out),
  .otn_section_severe_seconds_out(otn_section_severe_seconds_out),
  .otn_path_severe_seconds_out(otn_path_severe_seconds_out),
  .otn_section_severe_ratio_out(otn_section_severe_ratio_out),
  .otn_path_severe_ratio_out(otn_path_severe_ratio_out), .report_valid_out(report_valid_out));

// ---- verif/ssup_framer_model.sv ----
// Upstream framer model: spreads a per-second error total over the cycles of a second.
// Assumes the bench raises go_in only between ticks; tick_in restarts every channel.
module ssup_framer_model (
  input  wire logic             clock_in,
  input  wire logic             rstn_in,
  input  wire logic             tick_in,
  input  wire logic             go_in,
  input  wire logic [8:0][15:0] total_in,
  output logic      [8:0][3:0]  err_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0][15:0] sent_q;  // Errors already emitted this second.
  // Emit up to fifteen errors a cycle until the total is reached.
  always_comb begin
    for (int c = 0; c < 9; c++) begin
      if (!go_in || sent_q[c] >= total_in[c])
        err_out[c] = 4'h0;
      else if (total_in[c] - sent_q[c] > 16'h000F)
        err_out[c] = 4'hF;
      else
        err_out[c] = 4'(total_in[c] - sent_q[c]);
    end
  end
  // Count what was sent; a tick opens a fresh second.
  always @(posedge clock_in) begin
    for (int c = 0; c < 9; c++) begin
      if (!rstn_in || tick_in)
        sent_q[c] <= 16'h0000;
      else
        sent_q[c] <= sent_q[c] + {12'h000, err_out[c]};
    end
  end
endmodule // ssup_framer_model
